// File: rtl/timing_trigger_qualifier.sv
// Trigger qualification engine for six timing and logic trigger types
`timescale 1ns/1ps
module timing_trigger_qualifier import trig_qual_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic srst,
  input wire cfg_s cfg,
  input wire logic [NCH-1:0] chan,
  input wire logic slew_upper,
  input wire logic slew_lower,
  output logic trig_out,
  output cnt_t meas_out
);

  // ==========================================
  // Helper functions

  // Edge detect with optional direction lock
  function automatic logic edge_hit(
    logic cur,
    logic prv,
    edge_e sel,
    logic lock,
    logic lock_up
  );
    logic rise;
    logic fall;
    rise = cur & ~prv;
    fall = ~cur & prv;
    unique case (sel)
      ED_RISE: edge_hit = rise;
      ED_FALL: edge_hit = fall;
      default: edge_hit = lock ? (lock_up ? rise : fall) : (rise | fall);
    endcase
  endfunction

  // Duration check against width and delta
  function automatic logic range_hit(cnt_t m, range_e r, cnt_t w, cnt_t d);
    logic [CNT_W:0] lo;
    logic [CNT_W:0] hi;
    logic in_win;
    lo = (w >= d) ? {1'b0, w - d} : '0;
    hi = {1'b0, w} + {1'b0, d};
    in_win = ({1'b0, m} >= lo) && ({1'b0, m} <= hi);
    unique case (r)
      RG_SHORTER: range_hit = m < w;
      RG_LONGER: range_hit = m > w;
      RG_WITHIN: range_hit = in_win;
      RG_OUTSIDE: range_hit = ~in_win;
    endcase
  endfunction

  // Channel combination, excluded channels carry no state
  function automatic logic combine(
    logic [NCH-1:0] ch,
    logic [NCH-1:0] hi,
    logic [NCH-1:0] care,
    logic [NCH-1:0] excl,
    logic use_or
  );
    logic [NCH-1:0] m;
    m = (~care | ~(ch ^ hi)) & ~excl;
    combine = use_or ? |m : &(m | excl);
  endfunction

  // ==========================================
  // State

  logic [NCH-1:0] ch_prev_reg;
  logic up_prev_reg, lo_prev_reg, match_prev_reg, fire;
  trig_type_e type_prev_reg;
  range_e rng_prev_reg;
  cnt_t cnt_reg, cnt_next, dstab_reg, meas_next;
  logic arm_reg, arm_next, run_reg, run_next;
  logic run_up_reg, run_up_next, lock_reg, lock_next;
  logic lock_up_reg, lock_up_next;

  // ==========================================
  // Channel decode

  logic src, src_prv, clk_cur, clk_prv, dat_chg, cfg_chg, restart, src_edge;
  logic clk_edge, st_edge, to_ok, match, start_up, start_dn, slew_stop, slew_abort;
  logic [NCH-1:0] excl;
  cnt_t cnt_inc, dstab_now;

  // Selected sources, edges and restart conditions
  assign src = chan[cfg.src_sel];
  assign src_prv = ch_prev_reg[cfg.src_sel];
  assign clk_cur = chan[cfg.clk_sel];
  assign clk_prv = ch_prev_reg[cfg.clk_sel];
  assign dat_chg = chan[cfg.dat_sel] != ch_prev_reg[cfg.dat_sel];
  assign cfg_chg = (cfg.ttype != type_prev_reg) || (cfg.rng != rng_prev_reg);
  assign restart = srst | cfg_chg;
  assign src_edge = edge_hit(src, src_prv, cfg.edge_sel, 1'b0, 1'b0);
  assign clk_edge = edge_hit(clk_cur, clk_prv, cfg.edge_sel, 1'b0, 1'b0);
  assign st_edge = edge_hit(clk_cur, clk_prv, cfg.edge_sel, lock_reg, lock_up_reg);
  assign cnt_inc = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 1'b1;
  // Cycles since the last data change, counted up to and including this one
  assign dstab_now = dat_chg ? CNT_RST
    : (dstab_reg == CNT_MAX) ? dstab_reg : dstab_reg + 1'b1;

  // Timeout level qualification
  always_comb begin
    unique case (cfg.to_rng)
      TO_LOW: to_ok = ~src;
      TO_HIGH: to_ok = src;
      default: to_ok = 1'b1;
    endcase
  end

  // Pattern match, clock channel excluded in state mode
  assign excl = (cfg.ttype == TT_STATE) ? (NCH'(1) << cfg.clk_sel) : '0;
  assign match = combine(chan, cfg.st_hi, cfg.st_care, excl, cfg.use_or);

  // Slew start and stop crossings, direction locked when either
  assign start_up = lo_prev_reg == 1'b0 && slew_lower
    && (cfg.edge_sel == ED_RISE
    || (cfg.edge_sel == ED_EITHER && (!lock_reg || lock_up_reg)));
  assign start_dn = up_prev_reg && !slew_upper
    && (cfg.edge_sel == ED_FALL
    || (cfg.edge_sel == ED_EITHER && (!lock_reg || !lock_up_reg)));
  assign slew_stop = run_up_reg ? (slew_upper && !up_prev_reg)
    : (!slew_lower && lo_prev_reg);
  assign slew_abort = run_up_reg ? (!slew_lower && lo_prev_reg)
    : (slew_upper && !up_prev_reg);

  // ==========================================
  // Trigger evaluation
  always_comb begin
    fire = 1'b0;
    meas_next = meas_out;
    cnt_next = cnt_inc;
    arm_next = arm_reg;
    run_next = run_reg;
    run_up_next = run_up_reg;
    lock_next = lock_reg;
    lock_up_next = lock_up_reg;
    unique case (cfg.ttype)
      TT_TIMEOUT: begin
        if (src != src_prv) begin
          cnt_next = CNT_RST;
        end else if (to_ok && cnt_inc == cfg.tlimit && cnt_inc != cnt_reg) begin
          fire = 1'b1;
          meas_next = cnt_inc;
        end
      end
      TT_INTERVAL: begin
        if (src_edge) begin
          cnt_next = CNT_RST;
          arm_next = 1'b1;
          if (arm_reg) begin
            meas_next = cnt_inc;
            fire = range_hit(cnt_inc, cfg.rng, cfg.width, cfg.delta);
          end
        end
      end
      TT_SLEW: begin
        if (!run_reg) begin
          cnt_next = CNT_RST;
          if (start_up || start_dn) begin
            run_next = 1'b1;
            run_up_next = start_up;
            lock_next = 1'b1;
            lock_up_next = start_up;
          end
        end else if (slew_stop) begin
          run_next = 1'b0;
          meas_next = cnt_inc;
          fire = range_hit(cnt_inc, cfg.rng, cfg.width, cfg.delta);
        end else if (slew_abort) begin
          run_next = 1'b0;
        end
      end
      TT_SETHOLD: begin
        if (clk_edge) begin
          cnt_next = CNT_RST;
          arm_next = 1'b1;
          meas_next = dstab_now;
          fire = dat_chg || dstab_now < cfg.setup_t;
        end else if (arm_reg) begin
          if (dat_chg && cnt_inc <= cfg.hold_t) begin
            fire = 1'b1;
            arm_next = 1'b0;
          end else if (cnt_inc >= cfg.hold_t) begin
            arm_next = 1'b0;
          end
        end
      end
      TT_STATE: begin
        if (st_edge) begin
          fire = match;
          lock_next = 1'b1;
          lock_up_next = clk_cur;
        end
      end
      TT_PATTERN: begin
        fire = match && !match_prev_reg;
      end
      default: begin
        fire = 1'b0;
      end
    endcase
    if (restart) begin
      fire = 1'b0;
      cnt_next = CNT_RST;
      arm_next = 1'b0;
      run_next = 1'b0;
      lock_next = 1'b0;
    end
  end

  // ==========================================
  // Registers

  // Input history and configuration tracking
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch_prev_reg <= '0;
      up_prev_reg <= 1'b0;
      lo_prev_reg <= 1'b0;
      type_prev_reg <= TT_TIMEOUT;
      rng_prev_reg <= RG_SHORTER;
      match_prev_reg <= 1'b0;
    end else begin
      ch_prev_reg <= chan;
      up_prev_reg <= slew_upper;
      lo_prev_reg <= slew_lower;
      type_prev_reg <= cfg.ttype;
      rng_prev_reg <= cfg.rng;
      match_prev_reg <= match;
    end
  end

  // Measurement timers and sequence flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_RST;
      arm_reg <= 1'b0;
      run_reg <= 1'b0;
      run_up_reg <= 1'b0;
      lock_reg <= 1'b0;
      lock_up_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      arm_reg <= arm_next;
      run_reg <= run_next;
      run_up_reg <= run_up_next;
      lock_reg <= lock_next;
      lock_up_reg <= lock_up_next;
    end
  end

  // Data stability timer for setup checking
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dstab_reg <= CNT_RST;
    end else if (srst || dat_chg) begin
      dstab_reg <= CNT_RST;
    end else if (dstab_reg != CNT_MAX) begin
      dstab_reg <= dstab_reg + 1'b1;
    end
  end

  // Trigger pulse and last measurement
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trig_out <= 1'b0;
      meas_out <= CNT_RST;
    end else begin
      trig_out <= fire;
      meas_out <= srst ? CNT_RST : meas_next;
    end
  end

  // ==========================================
  // Checks

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!nrst);

  chk_reset_clear: assert property (
    srst |=> cnt_reg == CNT_RST && !trig_out && dstab_reg == CNT_RST)
    else $error("Reset did not clear timers");

  chk_timeout_fire: assert property (
    (cfg.ttype == TT_TIMEOUT && !restart && src == src_prv && to_ok
     && cnt_inc == cfg.tlimit && cnt_inc != cnt_reg) |=> trig_out)
    else $error("Timeout did not fire at limit");

  chk_timeout_level: assert property (
    (trig_out && $past(cfg.ttype) == TT_TIMEOUT && $past(cfg.to_rng) == TO_LOW)
    |-> !$past(src))
    else $error("Low timeout fired on high level");

  chk_interval_meas: assert property (
    (cfg.ttype == TT_INTERVAL && !restart && src_edge && arm_reg)
    |=> meas_out == $past(cnt_inc))
    else $error("Interval measurement wrong");

  chk_within_win: assert property (
    (trig_out && $past(cfg.ttype) == TT_INTERVAL && $past(cfg.rng) == RG_WITHIN)
    |-> {1'b0, meas_out} <= {1'b0, $past(cfg.width)} + {1'b0, $past(cfg.delta)})
    else $error("Within trigger above window");

  chk_shorter_lim: assert property (
    (trig_out && $past(cfg.rng) == RG_SHORTER
     && ($past(cfg.ttype) == TT_INTERVAL || $past(cfg.ttype) == TT_SLEW))
    |-> meas_out < $past(cfg.width))
    else $error("Shorter trigger not below width");

  chk_slew_stop: assert property (
    (trig_out && $past(cfg.ttype) == TT_SLEW) |-> $past(run_reg) && !run_reg)
    else $error("Slew trigger without running timer");

  chk_setup_viol: assert property (
    (cfg.ttype == TT_SETHOLD && !restart && clk_edge && dstab_now < cfg.setup_t)
    |=> trig_out)
    else $error("Setup violation missed");

  chk_state_match: assert property (
    (cfg.ttype == TT_STATE && !restart && st_edge) |=> trig_out == $past(match))
    else $error("State trigger disagrees with match");

  chk_pattern_edge: assert property (
    (cfg.ttype == TT_PATTERN && !restart) |=> trig_out == ($past(match)
     && !$past(match_prev_reg)))
    else $error("Pattern trigger wrong");

  chk_cfg_restart: assert property (
    cfg_chg |=> cnt_reg == CNT_RST && !arm_reg && !run_reg && !trig_out)
    else $error("Measurement not restarted");

  cov_interval_hit: cover property (trig_out && $past(cfg.ttype) == TT_INTERVAL);
  cov_slew_hit: cover property (trig_out && $past(cfg.ttype) == TT_SLEW);
  cov_sethold_hit: cover property (trig_out && $past(cfg.ttype) == TT_SETHOLD);
  cov_state_hit: cover property (trig_out && $past(cfg.ttype) == TT_STATE);

endmodule

// File: rtl/trig_qual_pkg.sv
// Shared types and constants for the trigger qualification engine
// Contract
// - Timeout fires after level held full limit
// - Timeout range picks low, high or either
// - Interval measures time between qualifying edges
// - Interval edges: rising, falling or both
// - Within: width minus delta to plus delta
// - Outside: below or above that window
// - Shorter/longer compare interval against width
// - Slew timer runs first to second threshold
// - Positive slope low to high, negative reversed
// - Slew within/outside uses width plus-minus delta
// - Slew shorter/longer compare against slew limit
// - Either edge locks onto first identified edge
// - Data steady setup before, hold after clock
// - Reference is selected clock crossing, chosen edge
// - Clock edge: rising, falling or both
// - Separate data and clock channel selections
// - State: sample combination at clock edge
// - Pattern: trigger on match, no clock
// - Combination is AND or OR of matches
// - State clock channel excluded from pattern
package trig_qual_pkg;

  // ==========================================
  // Sizes and reset values
  localparam int NCH = 4;
  localparam int CH_W = 2;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  typedef logic [CNT_W-1:0] cnt_t;

  // ==========================================
  // Mode encodings
  typedef enum logic [2:0] {
    TT_TIMEOUT, TT_INTERVAL, TT_SLEW, TT_SETHOLD, TT_STATE, TT_PATTERN
  } trig_type_e;

  typedef enum logic [1:0] {RG_SHORTER, RG_LONGER, RG_WITHIN, RG_OUTSIDE} range_e;

  typedef enum logic [1:0] {ED_RISE, ED_FALL, ED_EITHER} edge_e;

  typedef enum logic [1:0] {TO_LOW, TO_HIGH, TO_EITHER} to_range_e;

  // ==========================================
  // Configuration carrier
  typedef struct packed {
    trig_type_e ttype;
    range_e rng;
    edge_e edge_sel;
    to_range_e to_rng;
    logic use_or;
    logic [CH_W-1:0] src_sel;
    logic [CH_W-1:0] dat_sel;
    logic [CH_W-1:0] clk_sel;
    logic [NCH-1:0] st_hi;
    logic [NCH-1:0] st_care;
    cnt_t width;
    cnt_t delta;
    cnt_t tlimit;
    cnt_t setup_t;
    cnt_t hold_t;
  } cfg_s;

endpackage

// File: testbench/probe_front.sv
// Threshold comparator model that feeds the qualifier inputs
`timescale 1ns/1ps
module probe_front import trig_qual_pkg::*; (
  input wire logic [NCH-1:0] lvl_req,
  input wire logic up_req,
  input wire logic lo_req,
  output logic [NCH-1:0] chan,
  output logic slew_upper,
  output logic slew_lower
);
  // ==========================================
  // Comparators: a level above the upper threshold is also above the lower one
  assign chan = lvl_req;
  assign slew_upper = up_req;
  assign slew_lower = lo_req | up_req;
endmodule

// File: testbench/tb.sv
// Self-checking bench for the trigger qualification engine
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb import trig_qual_pkg::*; ;
  logic sys_clk, nrst, srst, up, lo, trig_out;
  cfg_s cfg;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] chan;
  logic slew_upper, slew_lower;
  cnt_t meas_out;
  int errors, checks, tcnt;

  // ==========================================
  // Design and comparator model
  probe_front pf (.lvl_req(lvl), .up_req(up), .lo_req(lo), .chan(chan),
    .slew_upper(slew_upper), .slew_lower(slew_lower));
  timing_trigger_qualifier uut (.sys_clk(sys_clk), .nrst(nrst), .srst(srst), .cfg(cfg),
    .chan(chan), .slew_upper(slew_upper), .slew_lower(slew_lower), .trig_out(trig_out),
    .meas_out(meas_out));

  // Clock and trigger pulse counter
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    #1;
    if (trig_out === 1'b1) tcnt++;
  end

  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic idle();
    cfg.ttype = trig_type_e'(3'h6);
    lvl = '0;
    up = 1'b0;
    lo = 1'b0;
    tick(3);
  endtask
  function automatic int hit(input range_e r, input int m, input int w, input int d);
    case (r)
      RG_SHORTER: return int'(m < w);
      RG_LONGER: return int'(m > w);
      RG_WITHIN: return int'(m >= w - d && m <= w + d);
      default: return int'(m < w - d || m > w + d);
    endcase
  endfunction
  task automatic to_case(input to_range_e r, input int n);
    idle();
    cfg.ttype = TT_TIMEOUT;
    cfg.to_rng = r;
    tick(1);
    tcnt = 0;
    lvl[2] = 1'b1;
    tick(6);
    lvl[2] = 1'b0;
    tick(7);
    `CHK(tcnt, n)
    `CHK(meas_out, 16'h0003)
  endtask
  task automatic iv(input edge_e e, input range_e r, input int h, input int l,
                    input int n, input int m);
    idle();
    cfg.ttype = TT_INTERVAL;
    cfg.rng = r;
    cfg.edge_sel = e;
    tick(2);
    tcnt = 0;
    repeat (3) begin
      lvl[2] = 1'b1;
      tick(h);
      lvl[2] = 1'b0;
      tick(l);
    end
    tick(3);
    `CHK(tcnt, n)
    `CHK(meas_out, cnt_t'(m))
  endtask
  task automatic sl(input edge_e e, input range_e r, input int k, input int n);
    idle();
    up = (e == ED_FALL);
    tick(2);
    cfg.ttype = TT_SLEW;
    cfg.rng = r;
    cfg.edge_sel = e;
    tick(2);
    tcnt = 0;
    lo = 1'b1;
    if (e == ED_FALL) up = 1'b0;
    tick(k);
    up = (e != ED_FALL);
    lo = (e != ED_FALL);
    tick(4);
    `CHK(tcnt, n)
    `CHK(meas_out, cnt_t'(k))
  endtask
  task automatic sh(input edge_e e, input int s, input int m, input int n);
    idle();
    cfg.ttype = TT_SETHOLD;
    cfg.edge_sel = e;
    tick(6);
    tcnt = 0;
    lvl[1] = 1'b1;
    tick(s);
    lvl[0] = 1'b1;
    if (m < 9) begin
      tick(m);
      lvl[1] = 1'b0;
    end
    tick(5);
    `CHK(tcnt, n)
    if (m > 8 && e != ED_FALL) `CHK(meas_out, cnt_t'(s))
  endtask
  task automatic st(input logic o, input logic [3:0] hi, input logic [3:0] care,
                    input logic [2:0] d, input int n);
    idle();
    cfg.ttype = TT_STATE;
    cfg.edge_sel = ED_RISE;
    cfg.use_or = o;
    cfg.st_hi = hi;
    cfg.st_care = care;
    lvl[2:0] = d;
    tick(2);
    tcnt = 0;
    lvl[3] = 1'b1;
    tick(3);
    `CHK(tcnt, n)
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #200000;
    errors++;
    finish_test();
  end

  // ==========================================
  // Test sequence
  initial begin
    nrst = 1'b0;
    srst = 1'b0;
    cfg = '0;
    lvl = '0;
    up = 1'b0;
    lo = 1'b0;
    errors = 0;
    checks = 0;
    tcnt = 0;
    cfg.src_sel = 2'h2;
    cfg.dat_sel = 2'h1;
    cfg.clk_sel = 2'h0;
    cfg.tlimit = 16'h0003;
    cfg.setup_t = 16'h0003;
    cfg.hold_t = 16'h0002;
    cfg.delta = 16'h0001;
    tick(2);
    nrst = 1'b1;
    tick(2);
    `CHK(trig_out, 1'b0)
    `CHK(meas_out, 16'h0000)
    to_case(TO_LOW, 1);
    to_case(TO_HIGH, 1);
    to_case(TO_EITHER, 2);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    `CHK(meas_out, 16'h0000)
    cfg.width = 16'h0006;
    for (int r = 0; r < 4; r++) begin
      for (int k = 4; k < 9; k++) iv(ED_RISE, range_e'(r), 1, k - 1,
        2 * hit(range_e'(r), k, 6, 1), k);
    end
    iv(ED_FALL, RG_WITHIN, 2, 4, 2, 6);
    iv(ED_EITHER, RG_SHORTER, 3, 3, 5, 3);
    idle();
    cfg.ttype = TT_INTERVAL;
    cfg.rng = RG_LONGER;
    cfg.edge_sel = ED_RISE;
    tick(2);
    tcnt = 0;
    lvl[2] = 1'b1;
    tick(1);
    lvl[2] = 1'b0;
    cfg.rng = RG_SHORTER;
    tick(2);
    lvl[2] = 1'b1;
    tick(1);
    lvl[2] = 1'b0;
    tick(3);
    `CHK(tcnt, 0)
    cfg.width = 16'h0004;
    for (int r = 0; r < 4; r++) begin
      for (int k = 2; k < 7; k++) sl(ED_RISE, range_e'(r), k,
        hit(range_e'(r), k, 4, 1));
    end
    sl(ED_FALL, RG_LONGER, 6, 1);
    sl(ED_EITHER, RG_WITHIN, 4, 1);
    sh(ED_RISE, 5, 99, 0);
    sh(ED_RISE, 3, 99, 0);
    sh(ED_RISE, 2, 99, 1);
    sh(ED_RISE, 5, 2, 1);
    sh(ED_RISE, 5, 3, 0);
    sh(ED_FALL, 2, 1, 0);
    sh(ED_EITHER, 2, 99, 1);
    cfg.clk_sel = 2'h3;
    st(1'b0, 4'b0101, 4'b1111, 3'b101, 1);
    st(1'b0, 4'b0101, 4'b1111, 3'b100, 0);
    st(1'b1, 4'b0101, 4'b1111, 3'b010, 0);
    st(1'b1, 4'b0101, 4'b1111, 3'b011, 1);
    st(1'b0, 4'b0001, 4'b0001, 3'b111, 1);
    st(1'b0, 4'b0000, 4'b0000, 3'b000, 1);
    lvl[3] = 1'b0;
    tick(3);
    lvl[3] = 1'b1;
    tick(3);
    `CHK(tcnt, 2)
    idle();
    cfg.ttype = TT_STATE;
    cfg.edge_sel = ED_EITHER;
    tick(2);
    tcnt = 0;
    lvl[3] = 1'b1;
    tick(3);
    lvl[3] = 1'b0;
    tick(3);
    lvl[3] = 1'b1;
    tick(3);
    `CHK(tcnt, 2)
    idle();
    cfg.ttype = TT_PATTERN;
    cfg.use_or = 1'b0;
    cfg.st_hi = 4'b0110;
    cfg.st_care = 4'b1110;
    tick(2);
    tcnt = 0;
    lvl = 4'b0111;
    tick(3);
    lvl = 4'b1111;
    tick(3);
    lvl = 4'b0110;
    tick(3);
    `CHK(tcnt, 2)
    cfg.use_or = 1'b1;
    cfg.st_hi = 4'b1000;
    cfg.st_care = 4'b1111;
    lvl = 4'b0111;
    tick(3);
    tcnt = 0;
    lvl = 4'b1111;
    tick(3);
    `CHK(tcnt, 1)
    finish_test();
  end
endmodule
